// >>> logic/acps_params.svh
// timing, field and reset constants for the conversion power sequencer
`ifndef ACPS_PARAMS_SVH
`define ACPS_PARAMS_SVH
`define ACPS_CLK_MHZ 100
`define ACPS_CYC_DN(ns) ((ns) * `ACPS_CLK_MHZ / 1000)
`define ACPS_T_PU_SHORT_NS 1500
`define ACPS_T_PU_REF_NS 30000
`define ACPS_T_PU_FULL_NS 182000
`define ACPS_T_CONV_NS 2300
`define ACPS_CTRL_W 10
`define ACPS_CTRL_RST 10'h000
`define ACPS_PD_HI_BIT 8
`define ACPS_PD_LO_BIT 7
`define ACPS_EXTERNAL_REFERENCE_SELECT_BIT 0
`define ACPS_CODE_W 10
`define ACPS_WORD_W 16
`define ACPS_RD_BITS 11
`define ACPS_WR_COMMIT 13
`define ACPS_FIFO_DEPTH 16
`define ACPS_SYNC_RST 5'h1c
`endif

// >>> logic/acps_pkg.sv
// shared types of the conversion power sequencer
package acps_pkg;
	typedef enum logic [4:0] {
		ST_OFF  = 5'h01,
		ST_WAKE = 5'h02,
		ST_IDLE = 5'h04,
		ST_CONV = 5'h08,
		ST_DONE = 5'h10
	} acps_state_e;
	typedef logic [1:0]  acps_pd_t;
	typedef logic [15:0] acps_word_t;
	typedef logic [14:0] acps_cnt_t;
endpackage

// >>> logic/acps_stream_if.sv
// valid/ready carrier from the sequencer into its result buffer and from the buffer to the read port
`timescale 1ns/10ps
interface acps_stream_if #(parameter int W = 10);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// >>> logic/acps_sync.sv
// two-stage synchroniser for the pin inputs
`timescale 1ns/10ps
module acps_sync #(
	parameter int           W   = 5,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= RST;
			s2_r <= RST;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
		end
	end

	assign q_o = s2_r;
endmodule

// >>> logic/acps_fifo.sv
// result buffer with registered read data
`timescale 1ns/10ps
module acps_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 16
) (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	acps_stream_if.snk in_s,
	acps_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic [W-1:0]  q_r, q_nxt;
	logic          qv_r, qv_nxt;
	logic          push, pop;

	always_comb begin
		push    = in_s.valid && in_s.ready;
		pop     = (cnt_r != '0) && (!qv_r || out_s.ready);
		wp_nxt  = push ? wp_r + AW'(1) : wp_r;
		rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		q_nxt   = pop ? mem_r[rp_r] : q_r;
		qv_nxt  = pop ? 1'b1 : (out_s.ready ? 1'b0 : qv_r);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			q_r   <= '0;
			qv_r  <= 1'b0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
			q_r   <= q_nxt;
			qv_r  <= qv_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_s.data;
		end
	end

	assign in_s.ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_s.data  = q_r;
	assign out_s.valid = qv_r;
endmodule

// >>> logic/acps_top.sv
// conversion and power sequencer with serial control and result port
`timescale 1ns/10ps
`include "acps_params.svh"
module acps_top import acps_pkg::*; #(
	parameter int PU_FULL_CYC = `ACPS_CYC_DN(`ACPS_T_PU_FULL_NS)
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    conversion_start_n_i,
	input  wire logic                    sclk_i,
	input  wire logic                    read_frame_sync_i,
	input  wire logic                    write_frame_sync_i,
	input  wire logic                    din_i,
	input  wire logic [`ACPS_CODE_W-1:0] sample_code_i,
	output logic                         dout_o,
	output logic                         dout_oe_n_o,
	output logic                         hold_o,
	output logic                         core_powered_o,
	output logic                         ref_powered_o,
	output logic                         external_reference_select_o,
	output logic                         power_mode_bit_hi_o,
	output logic                         power_mode_bit_lo_o
);
	localparam acps_cnt_t PU_SHORT_L =
		15'(`ACPS_CYC_DN(`ACPS_T_PU_SHORT_NS) - 1);
	localparam acps_cnt_t PU_REF_L = 15'(`ACPS_CYC_DN(`ACPS_T_PU_REF_NS) - 1);
	localparam acps_cnt_t PU_FULL_L = 15'(PU_FULL_CYC - 1);
	localparam acps_cnt_t CONV_L = 15'(`ACPS_CYC_DN(`ACPS_T_CONV_NS) - 1);
	localparam logic [3:0] RD_LAST = 4'(`ACPS_RD_BITS - 2);
	localparam logic [3:0] WR_LAST = 4'(`ACPS_WR_COMMIT - 1);
	localparam logic [3:0] WR_BITS = 4'(`ACPS_CTRL_W);
	localparam int         CONV_HOLD = `ACPS_CYC_DN(`ACPS_T_CONV_NS) - 1;
	localparam int         PU_SHORT_MAX = `ACPS_CYC_DN(`ACPS_T_PU_SHORT_NS);

	function automatic logic rose(input logic p, input logic c);
		return !p && c;
	endfunction

	function automatic logic word_bit(input acps_word_t w, input logic [3:0] i);
		return w[4'hf - i];
	endfunction

	function automatic logic mode2(input acps_pd_t pd);
		return pd == 2'b01 || pd == 2'b10;
	endfunction

	// pin synchronisers
	logic [4:0] pins_s;
	logic       cs_s, rfs_s, tfs_s, sclk_s, din_s;
	acps_sync #(.W(5), .RST(`ACPS_SYNC_RST)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({conversion_start_n_i, read_frame_sync_i,
			write_frame_sync_i, sclk_i, din_i}),
		.q_o   (pins_s)
	);
	assign {cs_s, rfs_s, tfs_s, sclk_s, din_s} = pins_s;

	// edge history
	logic cs_q, rfs_q, tfs_q, sclk_q;
	logic cs_rise, cs_fall, rfs_rise, tfs_fall, sclk_rise, sclk_fall;
	always_comb begin
		cs_rise   = rose(cs_q, cs_s);
		cs_fall   = rose(cs_s, cs_q);
		rfs_rise  = rose(rfs_q, rfs_s);
		tfs_fall  = rose(tfs_s, tfs_q);
		sclk_rise = rose(sclk_q, sclk_s);
		sclk_fall = rose(sclk_s, sclk_q);
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_q   <= 1'b1;
			rfs_q  <= 1'b1;
			tfs_q  <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			cs_q   <= cs_s;
			rfs_q  <= rfs_s;
			tfs_q  <= tfs_s;
			sclk_q <= sclk_s;
		end
	end

	// control write port
	logic [`ACPS_CTRL_W-1:0] ctrl_r, ctrl_nxt, wr_sh_r, wr_sh_nxt;
	logic [3:0]              wr_cnt_r, wr_cnt_nxt, wr_bits_r, wr_bits_nxt;
	logic                    wr_act_r, wr_act_nxt, lock_r, lock_nxt;
	acps_pd_t                pd, new_pd;
	logic                    ext_ref;

	always_comb begin
		wr_act_nxt  = wr_act_r;
		wr_cnt_nxt  = wr_cnt_r;
		wr_bits_nxt = wr_bits_r;
		wr_sh_nxt   = wr_sh_r;
		ctrl_nxt    = ctrl_r;
		lock_nxt    = lock_r;
		new_pd      = {wr_sh_r[`ACPS_PD_HI_BIT], wr_sh_r[`ACPS_PD_LO_BIT]};
		if (tfs_fall) begin
			wr_act_nxt  = 1'b1;
			wr_cnt_nxt  = 4'h0;
			wr_bits_nxt = 4'h0;
		end else if (wr_act_r) begin
			if (sclk_fall && wr_bits_r != WR_BITS) begin
				wr_sh_nxt   = {wr_sh_r[`ACPS_CTRL_W-2:0], din_s};
				wr_bits_nxt = wr_bits_r + 4'h1;
			end
			if (sclk_rise) begin
				if (wr_cnt_r == WR_LAST) begin
					ctrl_nxt   = wr_sh_r;
					wr_act_nxt = 1'b0;
					// conversions unlocked only by full power-up
					if (new_pd == 2'b11) begin
						lock_nxt = 1'b0;
					end
				end else begin
					wr_cnt_nxt = wr_cnt_r + 4'h1;
				end
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_act_r  <= 1'b0;
			wr_cnt_r  <= 4'h0;
			wr_bits_r <= 4'h0;
			wr_sh_r   <= `ACPS_CTRL_RST;
			ctrl_r    <= `ACPS_CTRL_RST;
			lock_r    <= 1'b1;
		end else begin
			wr_act_r  <= wr_act_nxt;
			wr_cnt_r  <= wr_cnt_nxt;
			wr_bits_r <= wr_bits_nxt;
			wr_sh_r   <= wr_sh_nxt;
			ctrl_r    <= ctrl_nxt;
			lock_r    <= lock_nxt;
		end
	end
	assign pd      = {ctrl_r[`ACPS_PD_HI_BIT], ctrl_r[`ACPS_PD_LO_BIT]};
	assign ext_ref = ctrl_r[`ACPS_EXTERNAL_REFERENCE_SELECT_BIT];

	// result buffer between converter and output shift register
	acps_stream_if #(.W(`ACPS_CODE_W)) cnv_s ();
	acps_stream_if #(.W(`ACPS_CODE_W)) res_s ();
	acps_fifo #(.W(`ACPS_CODE_W), .DEPTH(`ACPS_FIFO_DEPTH)) u_fifo (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.in_s  (cnv_s),
		.out_s (res_s)
	);

	// power and conversion sequencer
	acps_state_e             st_r, st_nxt;
	acps_cnt_t               cnt_r, cnt_nxt;
	logic                    pend_r, pend_nxt, chg_r, chg_nxt;
	logic [`ACPS_CODE_W-1:0] code_r, code_nxt;
	logic                    hold_r, pwr_r, refp_r;
	logic [8:0]              run_r, run_nxt;

	function automatic acps_cnt_t pu_load(input logic ext, input acps_pd_t m,
		input logic chg);
		if (ext || chg) begin
			return PU_SHORT_L;
		end else if (m == 2'b01) begin
			return PU_REF_L;
		end else begin
			return PU_FULL_L;
		end
	endfunction

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		pend_nxt = pend_r;
		chg_nxt  = chg_r;
		code_nxt = code_r;
		run_nxt  = (st_r == ST_CONV) ? run_r + 9'h001 : 9'h000;
		case (st_r)
			ST_OFF: begin
				pend_nxt = 1'b0;
				if (!lock_r && (pd == 2'b11 || (mode2(pd) && cs_rise))) begin
					st_nxt  = ST_WAKE;
					cnt_nxt = pu_load(ext_ref, pd, chg_r);
				end
			end
			ST_WAKE: begin
				if (cnt_r == '0) begin
					chg_nxt  = 1'b1;
					pend_nxt = 1'b0;
					if (pend_r || cs_fall) begin
						st_nxt  = ST_CONV;
						cnt_nxt = CONV_L;
					end else begin
						st_nxt = ST_IDLE;
					end
				end else begin
					cnt_nxt = cnt_r - 15'h0001;
					if (cs_fall) begin
						pend_nxt = 1'b1;
					end
				end
			end
			ST_IDLE: begin
				if (cs_fall) begin
					st_nxt  = ST_CONV;
					cnt_nxt = CONV_L;
				end
			end
			ST_CONV: begin
				if (cnt_r == '0) begin
					st_nxt   = ST_DONE;
					code_nxt = sample_code_i;
				end else begin
					cnt_nxt = cnt_r - 15'h0001;
				end
			end
			ST_DONE: begin
				// stalls while the buffer is full; level checked after load
				if (cnv_s.ready) begin
					if (!cs_s && mode2(pd)) begin
						st_nxt = ST_OFF;
					end else begin
						st_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				st_nxt = ST_OFF;
			end
		endcase
		if (pd == 2'b00) begin
			st_nxt  = ST_OFF;
			chg_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r   <= ST_OFF;
			cnt_r  <= '0;
			pend_r <= 1'b0;
			chg_r  <= 1'b0;
			code_r <= '0;
			run_r  <= 9'h000;
			hold_r <= 1'b0;
			pwr_r  <= 1'b0;
			refp_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			pend_r <= pend_nxt;
			chg_r  <= chg_nxt;
			code_r <= code_nxt;
			run_r  <= run_nxt;
			hold_r <= (st_nxt == ST_CONV);
			pwr_r  <= (st_nxt != ST_OFF) && (st_nxt != ST_WAKE);
			refp_r <= !ext_ref && (st_nxt != ST_OFF || (pd == 2'b01 && chg_nxt));
		end
	end
	assign cnv_s.valid = (st_r == ST_DONE);
	assign cnv_s.data  = code_r;

	// serial read port
	acps_word_t sh_r, sh_nxt;
	logic [3:0] rd_cnt_r, rd_cnt_nxt;
	logic       rd_arm_r, rd_arm_nxt, rd_act_r, rd_act_nxt;
	logic       dout_r, dout_nxt, doe_n_r, doe_n_nxt;
	logic       sh_load;

	always_comb begin
		rd_arm_nxt = rd_arm_r;
		rd_act_nxt = rd_act_r;
		rd_cnt_nxt = rd_cnt_r;
		dout_nxt   = dout_r;
		doe_n_nxt  = doe_n_r;
		sh_nxt     = sh_r;
		// no new result while a read runs
		sh_load    = res_s.valid && !rd_act_r && !(rd_arm_r && sclk_rise);
		if (sh_load) begin
			sh_nxt = {res_s.data, {(`ACPS_WORD_W-`ACPS_CODE_W){1'b0}}};
		end
		if (rfs_rise) begin
			rd_arm_nxt = 1'b1;
			rd_act_nxt = 1'b0;
			doe_n_nxt  = 1'b1;
		end else if (sclk_rise && rd_arm_r) begin
			rd_arm_nxt = 1'b0;
			rd_act_nxt = 1'b1;
			rd_cnt_nxt = 4'h0;
			dout_nxt   = word_bit(sh_r, 4'h0);
			doe_n_nxt  = 1'b0;
		end else if (sclk_rise && rd_act_r) begin
			if (rd_cnt_r == RD_LAST) begin
				rd_act_nxt = 1'b0;
				doe_n_nxt  = 1'b1;
			end else begin
				rd_cnt_nxt = rd_cnt_r + 4'h1;
				dout_nxt   = word_bit(sh_r, rd_cnt_r + 4'h1);
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_r     <= '0;
			rd_cnt_r <= 4'h0;
			rd_arm_r <= 1'b0;
			rd_act_r <= 1'b0;
			dout_r   <= 1'b0;
			doe_n_r  <= 1'b1;
		end else begin
			sh_r     <= sh_nxt;
			rd_cnt_r <= rd_cnt_nxt;
			rd_arm_r <= rd_arm_nxt;
			rd_act_r <= rd_act_nxt;
			dout_r   <= dout_nxt;
			doe_n_r  <= doe_n_nxt;
		end
	end
	assign res_s.ready = !rd_act_r && !(rd_arm_r && sclk_rise);

	assign dout_o                      = dout_r;
	assign dout_oe_n_o                 = doe_n_r;
	assign hold_o                      = hold_r;
	assign core_powered_o              = pwr_r;
	assign ref_powered_o               = refp_r;
	assign external_reference_select_o = ctrl_r[`ACPS_EXTERNAL_REFERENCE_SELECT_BIT];
	assign power_mode_bit_hi_o         = ctrl_r[`ACPS_PD_HI_BIT];
	assign power_mode_bit_lo_o         = ctrl_r[`ACPS_PD_LO_BIT];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	hold_on_start_a: assert property (
		st_r == ST_IDLE && cs_fall && pd != 2'b00 |=> st_r == ST_CONV && hold_r)
		else $error("hold not entered on start falling edge");
	conv_length_a: assert property (
		st_r == ST_DONE && $past(st_r == ST_CONV)
		|-> run_r == 9'(CONV_HOLD + 1))
		else $error("conversion length wrong");
	mode_two_a: assert property (
		st_r == ST_DONE && cnv_s.ready && !cs_s && mode2(pd) |=> st_r == ST_OFF)
		else $error("mode 2 did not power down");
	mode_one_a: assert property (
		st_r == ST_DONE && cnv_s.ready && cs_s && pd != 2'b00
		|=> st_r == ST_IDLE && pwr_r)
		else $error("mode 1 powered down");
	lock_refuse_a: assert property (
		lock_r |-> st_r == ST_OFF && !hold_r && !pwr_r)
		else $error("conversion allowed before power-up write");
	short_wake_a: assert property (
		st_r == ST_OFF && st_nxt == ST_WAKE && (ext_ref || chg_r)
		|=> ##[1:PU_SHORT_MAX] st_r != ST_WAKE)
		else $error("short wake-up too long");
	late_start_a: assert property (
		st_r == ST_WAKE && (pend_r || cs_fall) && pd != 2'b00
		|=> st_r == ST_CONV || (st_r == ST_WAKE && pend_r))
		else $error("start during wake-up lost");
	read_hiz_a: assert property (
		rd_act_r && sclk_rise && !rfs_rise && rd_cnt_r == RD_LAST
		|=> doe_n_r && !rd_act_r)
		else $error("output not released after last bit");
	load_wait_a: assert property (
		rd_act_r |=> $stable(sh_r) || $past(rfs_rise))
		else $error("shift register changed during read");
	ctrl_commit_a: assert property (
		wr_act_r && !tfs_fall && sclk_rise && wr_cnt_r == WR_LAST
		|=> ctrl_r == $past(wr_sh_r))
		else $error("control not updated on thirteenth edge");
endmodule

// >>> verification/acps_host_model.sv
// host serial port model: framed transfers on a link clock
`timescale 1ns/10ps
module acps_host_model (
	input  wire logic clk_i,
	input  wire logic dout_i,
	input  wire logic dout_oe_n_i,
	output logic      sclk_o,
	output logic      read_frame_sync_o,
	output logic      write_frame_sync_o,
	output logic      din_o
);
	logic last_r;
	logic dout_w;
	logic oe_pre;
	// released line shows the inverse of its last level
	assign dout_w = dout_oe_n_i ? ~last_r : dout_i;
	always @(posedge clk_i) begin
		if (!dout_oe_n_i)
			last_r <= dout_i;
	end
	initial begin
		sclk_o = 1'b0;
		read_frame_sync_o = 1'b0;
		write_frame_sync_o = 1'b1;
		din_o = 1'b0;
		last_r = 1'b0;
		oe_pre = 1'b1;
	end
	task automatic wait_n(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	// full duplex word, msb first; clock stands low between frames
	task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
		read_frame_sync_o = 1'b1;
		write_frame_sync_o = 1'b0;
		din_o = wr[15];
		wait_n(8);
		oe_pre = dout_oe_n_i;
		for (int i = 15; i >= 0; i--) begin
			sclk_o = 1'b1;
			wait_n(8);
			sclk_o = 1'b0;
			rd[i] = dout_w;
			wait_n(4);
			din_o = (i > 0) ? wr[i - 1] : ~wr[0];
			wait_n(4);
		end
		read_frame_sync_o = 1'b0;
		write_frame_sync_o = 1'b1;
		wait_n(16);
	endtask
endmodule

// >>> verification/test_acps_top.sv
// self-checking bench for the conversion power sequencer
`timescale 1ns/10ps
module test_acps_top;
	localparam int PU = 300;
	logic        clk, rst, cs_n, sclk, read_frame_sync, write_frame_sync, din, dout, oe_n, hold;
	logic        pow, refp, ext, pdh, pdl;
	logic [9:0]  code;
	logic [15:0] rd;
	int          err_count, checked, n;
	acps_top #(.PU_FULL_CYC(PU)) dut_u (
		.clk_i                       (clk),
		.rst_i                       (rst),
		.conversion_start_n_i        (cs_n),
		.sclk_i                      (sclk),
		.read_frame_sync_i           (read_frame_sync),
		.write_frame_sync_i          (write_frame_sync),
		.din_i                       (din),
		.sample_code_i               (code),
		.dout_o                      (dout),
		.dout_oe_n_o                 (oe_n),
		.hold_o                      (hold),
		.core_powered_o              (pow),
		.ref_powered_o               (refp),
		.external_reference_select_o (ext),
		.power_mode_bit_hi_o         (pdh),
		.power_mode_bit_lo_o         (pdl)
	);
	acps_host_model host_u (
		.clk_i              (clk),
		.dout_i             (dout),
		.dout_oe_n_i        (oe_n),
		.sclk_o             (sclk),
		.read_frame_sync_o  (read_frame_sync),
		.write_frame_sync_o (write_frame_sync),
		.din_o              (din)
	);
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic timeout(input string nm);
		err_count++;
		$display("mismatch %s exp done got timeout", nm);
		summarize();
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk16(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wait_pow(output int k);
		k = 0;
		while (pow !== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > 4000)
				timeout("power up");
		end
	endtask
	task automatic wake(input int e, input string nm);
		int k;
		cs_n = 1'b0;
		repeat (5) @(negedge clk);
		cs_n = 1'b1;
		wait_pow(k);
		chk1(nm, 1'b1, k >= e - 2 && k <= e + 10);
	endtask
	// start line low; raised after 21 cycles unless kept low
	task automatic convert(input logic [9:0] c, input logic keep_low,
		output int h);
		int k;
		h = 0;
		code = c;
		cs_n = 1'b0;
		for (k = 0; k < 600 && (h == 0 || hold === 1'b1); k++) begin
			@(negedge clk);
			if (k == 20 && !keep_low)
				cs_n = 1'b1;
			if (hold === 1'b1)
				h++;
		end
		if (k >= 600)
			timeout("conversion");
	endtask
	task automatic test_reset();
		logic seen;
		seen = 1'b0;
		chk1("dout enable", 1'b1, oe_n);
		chk1("core power", 1'b0, pow);
		chk1("mode hi", 1'b0, pdh);
		chk1("mode lo", 1'b0, pdl);
		cs_n = 1'b0;
		repeat (20) @(negedge clk);
		cs_n = 1'b1;
		repeat (300) begin
			@(negedge clk);
			seen = seen | hold | pow;
		end
		chk1("refused conversion", 1'b0, seen);
		$display("test reset done");
	endtask
	task automatic test_powerup();
		int k;
		fork
			host_u.xfer(16'h6040, rd);
			begin
				k = 0;
				while (pdh !== 1'b1) begin
					@(negedge clk);
					k++;
					if (k > 600)
						timeout("mode write");
				end
				wait_pow(k);
			end
		join
		chk1("ext ref wake", 1'b1, k >= 148 && k <= 160);
		chk1("mode hi", 1'b1, pdh);
		chk1("mode lo", 1'b1, pdl);
		chk1("ext ref", 1'b1, ext);
		$display("test powerup done");
	endtask
	task automatic test_mode1();
		convert(10'h2a5, 1'b0, n);
		chk1("hold length", 1'b1, n == 230);
		repeat (10) @(negedge clk);
		chk1("mode 1 power", 1'b1, pow);
		host_u.xfer(16'h4040, rd);
		chk16("result", 16'ha940, rd & 16'hffc0);
		chk1("port idle", 1'b1, host_u.oe_pre);
		chk1("port released", 1'b1, oe_n);
		chk1("mode lo", 1'b0, pdl);
		$display("test mode1 done");
	endtask
	task automatic test_mode2();
		int k;
		convert(10'h13c, 1'b1, n);
		repeat (5) @(negedge clk);
		chk1("mode 2 power", 1'b0, pow);
		host_u.xfer(16'h4040, rd);
		chk16("asleep read", 16'h4f00, rd & 16'hffc0);
		wake(150, "short wake");
		convert(10'h0aa, 1'b1, n);
		cs_n = 1'b1;
		repeat (10) @(negedge clk);
		cs_n = 1'b0;
		k = 10;
		while (hold !== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > 600)
				timeout("late hold");
		end
		chk1("powered at hold", 1'b1, pow);
		chk1("wake before hold", 1'b1, k >= 150);
		repeat (240) @(negedge clk);
		$display("test mode2 done");
	endtask
	task automatic test_overlap();
		wake(150, "wake again");
		fork
			convert(10'h351, 1'b0, n);
			begin
				repeat (100) @(negedge clk);
				host_u.xfer(16'h4040, rd);
			end
		join
		chk16("old result", 16'h2a80, rd & 16'hffc0);
		host_u.xfer(16'h4040, rd);
		chk16("new result", 16'hd440, rd & 16'hffc0);
		$display("test overlap done");
	endtask
	task automatic test_wake_modes();
		host_u.xfer(16'h0000, rd);
		chk1("mode 00 off", 1'b0, pow);
		host_u.xfer(16'h2000, rd);
		wake(3000, "first partial wake");
		convert(10'h3ff, 1'b1, n);
		repeat (5) @(negedge clk);
		chk1("partial sleep", 1'b0, pow);
		chk1("ref kept", 1'b1, refp);
		wake(150, "partial wake");
		host_u.xfer(16'h0000, rd);
		host_u.xfer(16'h4000, rd);
		wake(PU, "full wake");
		$display("test wake modes done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		err_count = 0;
		checked = 0;
		rst = 1'b1;
		cs_n = 1'b1;
		code = 10'h000;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		test_reset();
		test_powerup();
		test_mode1();
		test_mode2();
		test_overlap();
		test_wake_modes();
		summarize();
	end
endmodule
